// ### design/ssp_map.svh
// constants for the sensor serial slave port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_BIT_CNT_W     5
`define SSP_ADDR_BITS     5'h08
`define SSP_XFER_BITS     5'h10
`define SSP_DIR_POS       7
`define SSP_BURST_ADDR_W  7'h50
`define SSP_BURST_ADDR_S  7'h60
`define SSP_BURST_ADDR_P  7'h40
`endif

// ### design/ssp_pkg.sv
// types for the sensor serial slave port
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_ADDR  = 2'b01,
    SSP_DATA  = 2'b10,
    SSP_BLOCK = 2'b11
  } ssp_state_t;
endpackage

// ### design/ssp_sync.sv
// two flop synchroniser for a level
`timescale 1ns/1ps
module ssp_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ssp_sync_t;
  ssp_sync_t st;
  ssp_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    if (!rst_n_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign q_o = st.s2;
endmodule // ssp_sync

// ### design/ssp_top.sv
// sensor serial slave port: spi slave on its own clock, register access on clk_i
//
// What this block does
// - master alone starts transfers; device only answers
// - power down or reset refuses access; a burst address still blocks the port
// - deselected: ignore clock and data, miso high-z
// - port enabled only after chip select falls
// - chip select rise aborts, returns to idle
// - burst ends by chip select; else refused
// - write: 1, seven-bit address, data byte
// - mosi sampled on rising sclk edges, except while a burst address blocks the port
// - read: 0, address, device returns data byte
// - read bits shifted out on falling sclk
// - miso held until next falling sclk edge
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_top
  import ssp_pkg::*;
(
  // core clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // device pins on the core side
  input  wire logic       power_down_n_i,
  input  wire logic       sensor_reset_i,
  // serial link
  input  wire logic       sclk_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_n_o,
  // register side, clk_i domain
  output logic            wr_strobe_o,
  output logic            rd_strobe_o,
  output logic [6:0]      reg_addr_o,
  output logic [7:0]      wr_data_o,
  input  wire logic [7:0] rd_data_i,
  output logic            burst_o
);

  ////////////////////////////////////////////////////////////////////////
  // core domain: port enable to link domain, handshake from link domain

  typedef struct packed {
    logic       en;
    logic       wr_seen;
    logic       rd_seen;
    logic       wr_strobe;
    logic       rd_strobe;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       burst;
  } ssp_core_t;

  ssp_core_t cs;
  ssp_core_t next_cs;

  // link events arrive as toggles, synchronised into clk_i
  logic wr_tog_l;
  logic rd_tog_l;
  logic wr_tog_c;
  logic rd_tog_c;
  logic en_l;
  logic brst_l;
  logic [6:0] addr_l;
  logic [7:0] wdata_l;

  ssp_sync u_sync_wr (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (wr_tog_l),
    .q_o     (wr_tog_c)
  );

  ssp_sync u_sync_rd (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (rd_tog_l),
    .q_o     (rd_tog_c)
  );

  logic pd_n_c;
  logic rst_c;

  ssp_sync u_sync_pd (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (power_down_n_i),
    .q_o     (pd_n_c)
  );

  ssp_sync u_sync_rst (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (sensor_reset_i),
    .q_o     (rst_c)
  );

  // burst level leaves the link domain through two flops
  logic brst_c;

  ssp_sync u_sync_bst (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (brst_l),
    .q_o     (brst_c)
  );

  always_comb begin
    next_cs           = cs;
    next_cs.wr_strobe = 1'b0;
    next_cs.rd_strobe = 1'b0;
    // power down or reset keeps port off
    next_cs.en        = pd_n_c & ~rst_c;
    next_cs.wr_seen   = wr_tog_c;
    next_cs.rd_seen   = rd_tog_c;
    // address and data are stable in link flops when the toggle lands
    if (wr_tog_c != cs.wr_seen) begin
      next_cs.wr_strobe = 1'b1;
      next_cs.addr      = addr_l;
      next_cs.wdata     = wdata_l;
    end
    if (rd_tog_c != cs.rd_seen) begin
      next_cs.rd_strobe = 1'b1;
      next_cs.addr      = addr_l;
    end
    // read data captured one cycle after the strobe
    if (cs.rd_strobe) begin
      next_cs.rdata = rd_data_i;
    end
    next_cs.burst = brst_c;
    if (!rst_n_i) begin
      next_cs = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    cs <= next_cs;
  end

  assign wr_strobe_o = cs.wr_strobe;
  assign rd_strobe_o = cs.rd_strobe;
  assign reg_addr_o  = cs.addr;
  assign wr_data_o   = cs.wdata;
  assign burst_o     = cs.burst;

  ////////////////////////////////////////////////////////////////////////
  // link domain: port enable crosses with two sclk flops

  logic link_rst_n;
  assign link_rst_n = ~chip_select_n_i;

  typedef struct packed {
    logic e1;
    logic e2;
  } ssp_lsync_t;

  ssp_lsync_t ls;
  ssp_lsync_t next_ls;

  // no reset: read only after seven sclk edges of a frame, so it has settled
  always_comb begin
    next_ls    = ls;
    next_ls.e1 = cs.en;
    next_ls.e2 = ls.e1;
  end

  always_ff @(posedge sclk_i) begin
    ls <= next_ls;
  end

  assign en_l = ls.e2;

  // frame state, cleared whenever chip select is high
  typedef struct packed {
    ssp_state_t                st;
    logic [`SSP_BIT_CNT_W-1:0] cnt;
    logic [7:0]                sh;
    logic                      dir_wr;
    logic                      ok;
    logic                      burst;
    logic                      blk;
  } ssp_link_t;

  // words and toggles read by the core, kept across deselect
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       wr_tog;
    logic       rd_tog;
  } ssp_keep_t;

  ssp_link_t lk;
  ssp_link_t next_lk;
  ssp_keep_t kp;
  ssp_keep_t next_kp;

  // these addresses leave the port blocked after one transfer
  function automatic logic is_burst(input logic [6:0] a);
    is_burst = (a == `SSP_BURST_ADDR_W) || (a == `SSP_BURST_ADDR_S)
               || (a == `SSP_BURST_ADDR_P);
  endfunction

  // low seven bits of the byte that completes on this edge
  function automatic logic [6:0] addr_of(input logic [7:0] s, input logic b);
    addr_of = {s[5:0], b};
  endfunction

  always_comb begin
    next_lk = lk;
    next_kp = kp;
    unique case (lk.st)
      // link leaves reset only while chip select is low
      SSP_IDLE: begin
        next_lk.st     = SSP_ADDR;
        next_lk.sh     = {7'h00, mosi_i};
        next_lk.dir_wr = mosi_i;
        next_lk.cnt    = 5'h01;
      end
      SSP_ADDR: begin
        next_lk.sh  = {lk.sh[6:0], mosi_i};
        next_lk.cnt = lk.cnt + 5'h01;
        if (lk.cnt == `SSP_ADDR_BITS - 5'h01) begin
          next_lk.st    = SSP_DATA;
          next_lk.burst = is_burst(addr_of(lk.sh, mosi_i));
          // refused frame commits nothing; a burst address still leaves the port blocked
          next_lk.ok    = en_l;
          if (en_l) begin
            // low seven bits are the address
            next_kp.addr = addr_of(lk.sh, mosi_i);
            if (!lk.dir_wr) begin
              next_kp.rd_tog = ~kp.rd_tog;
            end
          end
        end
      end
      SSP_DATA: begin
        next_lk.sh  = {lk.sh[6:0], mosi_i};
        next_lk.cnt = lk.cnt + 5'h01;
        if (lk.cnt == `SSP_XFER_BITS - 5'h01) begin
          if (lk.dir_wr && lk.ok) begin
            next_kp.wdata  = {lk.sh[6:0], mosi_i};
            next_kp.wr_tog = ~kp.wr_tog;
          end
          next_lk.st  = lk.burst ? SSP_BLOCK : SSP_IDLE;
          next_lk.blk = lk.burst;
          next_lk.cnt = 5'h00;
        end
      end
      SSP_BLOCK: begin
        next_lk.cnt = 5'h00;
      end
    endcase
  end

  // chip select high resets link state
  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // toggles survive deselect, so the crossing never sees a false event;
  // core reset clears them while sclk is idle, keeping both sides equal
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kp <= '0;
    end else begin
      kp <= next_kp;
    end
  end

  assign wr_tog_l = kp.wr_tog;
  assign rd_tog_l = kp.rd_tog;
  assign addr_l   = kp.addr;
  assign wdata_l  = kp.wdata;
  // a single flop, so the synchroniser never sees a decode glitch
  assign brst_l   = lk.blk;

  ////////////////////////////////////////////////////////////////////////
  // output side on falling sclk

  typedef struct packed {
    logic [7:0] osh;
    logic       oe_n;
  } ssp_out_t;

  ssp_out_t os;
  ssp_out_t next_os;

  // falling edge shifts read data out
  always_comb begin
    next_os      = os;
    next_os.oe_n = 1'b1;
    if (lk.st == SSP_DATA && !lk.dir_wr && lk.ok) begin
      // drives only inside an accepted master read
      next_os.oe_n = 1'b0;
      if (lk.cnt == `SSP_ADDR_BITS) begin
        // rdata is quasi-static: the address-to-data wait outlasts its capture
        next_os.osh = cs.rdata;
      end else begin
        next_os.osh = {os.osh[6:0], 1'b0};
      end
    end
  end

  // value held until the next falling edge
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      // shifter clear, output released
      os <= 9'h001;
    end else begin
      os <= next_os;
    end
  end

  assign miso_o      = os.osh[7];
  assign miso_oe_n_o = os.oe_n;

endmodule // ssp_top

// ### test/ssp_host.sv
// host model: serial bus master on the link
`timescale 1ns/1ps
module ssp_host (
  // link pins
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // odd delay keeps link edges off the core clock edges
  task automatic cs(input logic v);
    cs_n_o = v;
    #53.3;
  endtask
  task automatic shift(input logic [15:0] w, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (i == 8) #500;
      sclk_o = 1'b0;
      mosi_o = w[15-i];
      #15;
      sclk_o = 1'b1;
      r = {r[6:0], miso_i};
      #15;
    end
    mosi_o = ~mosi_o;
  endtask
endmodule // ssp_host

// ### test/ssp_top_sva.sv
// assertions on the serial slave port
`timescale 1ns/1ps
module ssp_top_sva (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       power_down_n_i,
  input wire logic       sensor_reset_i,
  input wire logic       sclk_i,
  input wire logic       chip_select_n_i,
  input wire logic       miso_o,
  input wire logic       miso_oe_n_o,
  input wire logic       wr_strobe_o,
  input wire logic       rd_strobe_o,
  input wire logic [6:0] reg_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic       burst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire stb = wr_strobe_o | rd_strobe_o;
  // six cycles covers the sync chain plus strobe latency
  sequence s_desel; chip_select_n_i [*6]; endsequence
  sequence s_off; (!power_down_n_i || sensor_reset_i) [*6]; endsequence
  property p_hiz; chip_select_n_i |-> miso_oe_n_o; endproperty
  property p_off; s_off |-> !stb; endproperty
  property p_desel; s_desel |-> !stb; endproperty
  property p_burst; s_desel |-> !burst_o; endproperty
  property p_pulse; wr_strobe_o |-> !rd_strobe_o ##1 !wr_strobe_o; endproperty
  property p_wdata; $changed(wr_data_o) |-> wr_strobe_o; endproperty
  property p_addr; $changed(reg_addr_o) |-> stb; endproperty
  property p_miso; !chip_select_n_i && !miso_oe_n_o && $changed(miso_o) |-> !sclk_i; endproperty
  a_hiz: assert property (p_hiz) else $error("miso not released");
  a_off: assert property (p_off) else $error("access while off");
  a_desel: assert property (p_desel) else $error("access unselected");
  a_burst: assert property (p_burst) else $error("burst kept");
  a_pulse: assert property (p_pulse) else $error("bad strobe");
  a_wdata: assert property (p_wdata) else $error("data moved");
  a_addr: assert property (p_addr) else $error("address moved");
  a_miso: assert property (p_miso) else $error("miso off edge");
endmodule // ssp_top_sva
bind ssp_top ssp_top_sva u_sva (.clk_i, .rst_n_i, .power_down_n_i, .sensor_reset_i, .sclk_i,
  .chip_select_n_i, .miso_o, .miso_oe_n_o, .wr_strobe_o, .rd_strobe_o, .reg_addr_o,
  .wr_data_o, .burst_o);

// ### test/ssp_top_tb.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_top_tb;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       pd_n = 1'b1;
  logic       srst = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] r, wd;
  logic [6:0] a;
  logic       d, kind;
  wire        sclk, cs_n, mosi, miso, oe_n, wr_stb, rd_stb, burst;
  wire  [6:0] reg_addr;
  wire  [7:0] wr_data;
  wire        miso_line = oe_n ? 1'bz : miso;
  int         num_errors = 0;
  int         checks_done = 0;
  int         nstb = 0;
  int         n0;
  ssp_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line));
  ssp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .power_down_n_i(pd_n), .sensor_reset_i(srst),
    .sclk_i(sclk), .chip_select_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(oe_n),
    .wr_strobe_o(wr_stb), .rd_strobe_o(rd_stb), .reg_addr_o(reg_addr), .wr_data_o(wr_data),
    .rd_data_i(rd_data), .burst_o(burst));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (wr_stb | rd_stb) begin
    nstb <= nstb + 1;
    kind <= wr_stb;
  end
  function automatic logic [6:0] safe(input logic [6:0] x);
    return (x inside {`SSP_BURST_ADDR_W, `SSP_BURST_ADDR_S, `SSP_BURST_ADDR_P}) ? 7'h11 : x;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic tr(input logic [15:0] w, input int n);
    n0 = nstb;
    host.cs(1'b0);
    host.shift(w, n, r);
    host.cs(1'b1);
    // spacing scaled to what the port needs
    step(30);
  endtask
  initial begin
    void'($urandom(53017));
    step(5);
    rst_n_i = 1'b1;
    tr(16'h0000, 4);
    for (int j = 0; j < 3; j++) begin
      a = j == 0 ? `SSP_BURST_ADDR_W : j == 1 ? `SSP_BURST_ADDR_S : `SSP_BURST_ADDR_P;
      host.cs(1'b0);
      host.shift({a == `SSP_BURST_ADDR_S, a, 8'h00}, 16, r);
      step(10);
      n0 = nstb;
      host.shift({1'b1, 7'h11, 8'h5a}, 16, r);
      step(10);
      chk(8'(burst), 8'h01);
      chk(8'(nstb - n0), 8'h00);
      host.cs(1'b1);
      #4000;
      chk(8'(burst), 8'h00);
    end
    for (int k = 1; k < 16; k += 7) begin
      tr({1'b1, 7'h22, 8'h33}, k);
      chk(8'(nstb - n0), 8'h00);
    end
    n0 = nstb;
    host.shift(16'hffff, 16, r);
    step(10);
    chk(8'(nstb - n0), 8'h00);
    chk(8'(oe_n), 8'h01);
    for (int k = 0; k < 2; k++) begin
      pd_n = k[0];
      srst = k[0];
      step(10);
      tr({1'b1, 7'h22, 8'h33}, 16);
      chk(8'(nstb - n0), 8'h00);
      pd_n = 1'b1;
      srst = 1'b0;
      step(10);
      tr(16'h0000, 4);
    end
    // edge addresses first, then random traffic
    for (int i = 0; i < 16; i++) begin
      a = i == 0 ? 7'h7f : i == 1 ? 7'h00 : safe(7'($urandom));
      d = i == 0 ? 1'b1 : i == 1 ? 1'b0 : 1'($urandom);
      wd = 8'($urandom);
      rd_data = 8'($urandom);
      tr({d, a, wd}, 16);
      chk(8'(nstb - n0), 8'h01);
      chk(8'(kind), 8'(d));
      chk({1'b0, reg_addr}, {1'b0, a});
      chk(d ? wr_data : r, d ? wd : rd_data);
    end
    results();
  end
  initial begin
    #300000;
    num_errors++;
    results();
  end
endmodule // ssp_top_tb
